// ---- pkg/dsl_pkg.sv ----
// constants and types for the serial-input dac latch control block
// Functional notes
// - latch load low makes the dac latch transparent to the input register
// - converter code output changes in the same cycle the latch updates
// - reset loads 8000h with reset select high, 0000h when low
// - gain strap low gives buffer gain 1, high gives gain 2
// - format strap high means straight binary, low means two's complement
// - active-low hardware reset input performs a full reset
// - power-down input high parks output, grounded through 10k resistor
// - serial clock edges shift nothing unless chip select is low
// - serial data output is high impedance while chip select is high
// - stand-alone mode shifts out the existing input register contents
// - daisy-chain mode shifts out the serial input shift register contents
// - one channel with a 16-bit code in input register and latch
// - output holds the reset code until a valid serial write arrives
package dsl_pkg;
    localparam int          DSL_CODE_W     = 16;
    localparam int          DSL_CNT_W      = 5;
    localparam logic [15:0] DSL_RESET_MID  = 16'h8000;
    localparam logic [15:0] DSL_RESET_ZERO = 16'h0000;
    localparam logic [15:0] DSL_SIGN_FLIP  = 16'h8000;
    localparam logic [4:0]  DSL_FRAME_BITS = 5'h10;
    localparam int          DSL_BUF_DEPTH  = 2;

    // frame state, gray coded along idle -> shift -> done
    typedef enum logic [1:0] {
        DSL_IDLE  = 2'h0,
        DSL_SHIFT = 2'h1,
        DSL_DONE  = 2'h3
    } dsl_state_type;
endpackage

// ---- hdl/dsl_top.sv ----
// serial input, input register and dac latch control for a 16-bit dac
`timescale 1ns/1ps
module dsl_top (
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    // device pins
    input  wire logic                         reset_n,
    input  wire logic                         power_down_input,
    input  wire logic                         latch_load_n,
    // strap pins
    input  wire logic                         reset_value_select,
    input  wire logic                         gain_select,
    input  wire logic                         data_format_select,
    input  wire logic                         serial_out_select,
    // serial link
    input  wire logic                         sclk,
    input  wire logic                         cs_n,
    input  wire logic                         sdi,
    output logic                              sdo,
    output logic                              sdo_oe,
    // converter side
    output logic [dsl_pkg::DSL_CODE_W-1:0]    dac_code,
    output logic                              gain_two,
    output logic                              out_ground_10k,
    output logic                              word_ready
);
    import dsl_pkg::*;

    // latency in ref_clk cycles after a pin moves:
    //   two cycles through the synchronisers, one more for edge detection,
    //   so a chip select rise reaches the input register about five cycles
    //   later, and the converter code one cycle after that with the latch open.
    // the link clock is oversampled, so each sclk level must last three cycles;
    // faster links need a link-clocked front end, which this block trades away
    // for a single clock domain with no crossing inside the data path.

    // two-stage synchronisers for the control and link pins
    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    always_ff @(posedge ref_clk) begin
        pin_s1_r <= {reset_n, power_down_input, latch_load_n, sclk, cs_n, sdi};
        pin_s2_r <= pin_s1_r;
    end
    wire rstn_s = pin_s2_r[5];
    wire pd_s   = pin_s2_r[4];
    wire ldn_s  = pin_s2_r[3];
    wire sclk_s = pin_s2_r[2];
    wire csn_s  = pin_s2_r[1];
    wire sdi_s  = pin_s2_r[0];

    // straps are pins too; they pass the same two stages before capture
    logic [3:0] strap_s1_r;
    logic [3:0] strap_s2_r;
    always_ff @(posedge ref_clk) begin
        strap_s1_r <= {reset_value_select, gain_select, data_format_select, serial_out_select};
        strap_s2_r <= strap_s1_r;
    end
    wire rsel_s = strap_s2_r[3];
    wire gain_s = strap_s2_r[2];
    wire fmt_s  = strap_s2_r[1];
    wire osel_s = strap_s2_r[0];

    // either reset initialises all but synchronisers, edge delay flops and buffer storage; the pin reset acts after its
    // synchroniser delay and holds for as long as the pin stays low
    wire full_rst = rst | ~rstn_s;

    // edge detection on synchronised link clock and chip select; the delay
    // flops keep following their pins through reset, so no false edge
    // appears when reset lets go
    logic sclk_d_r;
    logic csn_d_r;
    always_ff @(posedge ref_clk) begin
        sclk_d_r <= sclk_s;
        csn_d_r  <= csn_s;
    end
    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire sclk_fall = ~sclk_s & sclk_d_r;
    wire cs_rise   = csn_s & ~csn_d_r;
    wire cs_fall   = ~csn_s & csn_d_r;

    // straps captured while reset is held, frozen afterwards; a strap that
    // moves in operation has no effect until the next reset
    logic rsel_r;
    logic gain_r;
    logic fmt_r;
    logic osel_r;
    always_ff @(posedge ref_clk) begin
        if (full_rst) begin
            rsel_r <= rsel_s;
            gain_r <= gain_s;
            fmt_r  <= fmt_s;
            osel_r <= osel_s;
        end
    end

    // reset code chosen by the captured reset select strap
    function automatic logic [15:0] reset_word(input logic sel);
        reset_word = sel ? DSL_RESET_MID : DSL_RESET_ZERO;
    endfunction

    // two's complement words become straight binary by flipping the sign bit
    function automatic logic [15:0] to_binary(input logic [15:0] w, input logic straight);
        to_binary = straight ? w : (w ^ DSL_SIGN_FLIP);
    endfunction

    wire [15:0] reset_code = reset_word(rsel_r);

    // frame state and shift register; take_bit stops at a full word, so a
    // long frame cannot push the first bits out again
    dsl_state_type state_r;
    dsl_state_type state_nxt;
    logic [15:0]   shift_r;
    logic [4:0]    cnt_r;
    logic [15:0]   out_r;
    logic          sdo_r;
    wire  active   = ~csn_s;
    wire  take_bit = active & sclk_rise & (cnt_r != DSL_FRAME_BITS);
    wire  full_frm = (cnt_r == DSL_FRAME_BITS);

    // next-state logic; an incomplete frame is dropped at chip select rise
    // without reaching the buffer; done lasts exactly one cycle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DSL_IDLE: begin
                if (cs_fall) begin
                    state_nxt = DSL_SHIFT;
                end
            end
            DSL_SHIFT: begin
                if (cs_rise) begin
                    state_nxt = full_frm ? DSL_DONE : DSL_IDLE;
                end
            end
            DSL_DONE: begin
                state_nxt = DSL_IDLE;
            end
            default: begin
                state_nxt = DSL_IDLE;
            end
        endcase
    end

    // two-entry buffer between the shifter and the input register; the drain
    // side is always ready, so it never fills in practice, but it keeps a
    // word safe should the input register side ever stall
    logic [15:0] buf_mem [DSL_BUF_DEPTH];
    logic        wptr_r;
    logic        rptr_r;
    logic [1:0]  fill_r;
    wire  buf_in_valid  = (state_r == DSL_DONE);
    wire  buf_in_ready  = (fill_r != 2'h2);
    wire  buf_out_valid = (fill_r != 2'h0);
    wire  buf_out_ready = 1'b1; // input register always accepts
    wire  buf_push      = buf_in_valid & buf_in_ready;
    wire  buf_pop       = buf_out_valid & buf_out_ready;
    assign word_ready   = buf_in_ready;

    // format conversion to straight binary before the input register
    wire [15:0] buf_head = buf_mem[rptr_r];
    wire [15:0] conv     = to_binary(buf_head, fmt_r);

    // frame state register
    always_ff @(posedge ref_clk) begin
        if (full_rst) begin
            state_r <= DSL_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // bit counter: restarts at each frame start, saturates at a full word
    // so that surplus clocks in a long frame are ignored
    always_ff @(posedge ref_clk) begin
        if (full_rst) begin
            cnt_r <= 5'h00;
        end else if (cs_fall) begin
            cnt_r <= 5'h00;
        end else if (take_bit) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end

    // serial input shift register, msb first; it keeps its content between
    // frames because daisy-chain readback sends it on in the next frame
    always_ff @(posedge ref_clk) begin
        if (full_rst) begin
            shift_r <= 16'h0000;
        end else if (take_bit & ~cs_fall) begin
            shift_r <= {shift_r[14:0], sdi_s};
        end
    end

    // buffer storage; a word arriving with the buffer full is dropped
    always_ff @(posedge ref_clk) begin
        if (!full_rst && buf_push) begin
            buf_mem[wptr_r] <= shift_r;
        end
    end

    // pointers: write side advances on push, read side on pop
    always_ff @(posedge ref_clk) begin
        if (full_rst) begin
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
        end else begin
            if (buf_push) begin
                wptr_r <= ~wptr_r;
            end
            if (buf_pop) begin
                rptr_r <= ~rptr_r;
            end
        end
    end

    // fill count; a push and a pop in one cycle leave it unchanged
    always_ff @(posedge ref_clk) begin
        if (full_rst) begin
            fill_r <= 2'h0;
        end else begin
            fill_r <= fill_r + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    // input register: takes each word that the buffer hands over
    logic [15:0] in_reg_r;
    logic [15:0] latch_r;
    always_ff @(posedge ref_clk) begin
        if (full_rst) begin
            in_reg_r <= reset_code;
        end else if (buf_pop) begin
            in_reg_r <= conv;
        end
    end

    // dac latch: transparent while the load pin is low, so it copies the
    // input register every cycle; a held pin freezes the converter code
    always_ff @(posedge ref_clk) begin
        if (full_rst) begin
            latch_r <= reset_code;
        end else if (!ldn_s) begin
            latch_r <= in_reg_r;
        end
    end
    // code follows the latch directly, no extra stage
    assign dac_code = latch_r;

    // readback source picked at frame start; stand-alone sends the input
    // register, daisy-chain sends what the shifter held from the last frame
    wire [15:0] rb_src   = osel_r ? in_reg_r : shift_r;
    wire        rb_shift = active & sclk_fall;

    // readback word: loaded at frame start, moved one place per falling clock
    always_ff @(posedge ref_clk) begin
        if (full_rst) begin
            out_r <= 16'h0000;
        end else if (cs_fall) begin
            out_r <= rb_src;
        end else if (rb_shift) begin
            out_r <= {out_r[14:0], 1'b0};
        end
    end

    // output bit register: the pin changes just after a falling clock and
    // stands through the following high phase, where the host samples it
    always_ff @(posedge ref_clk) begin
        if (full_rst) begin
            sdo_r <= 1'b0;
        end else if (cs_fall) begin
            sdo_r <= rb_src[15];
        end else if (rb_shift) begin
            sdo_r <= out_r[14];
        end
    end

    // the pin is released whenever chip select is high; the pad turns the
    // low enable into high impedance outside the core
    assign sdo    = sdo_r;
    assign sdo_oe = active;

    // static analog controls from frozen straps and power-down pin; the
    // indication tells the analog side to park the output on its grounding
    // resistor, while the digital state is kept for the return to operation
    logic pd_r;
    always_ff @(posedge ref_clk) begin
        if (full_rst) begin
            pd_r <= 1'b0;
        end else begin
            pd_r <= pd_s;
        end
    end
    assign gain_two       = gain_r;
    assign out_ground_10k = pd_r;
endmodule

// ---- bench/dsl_top_props.sv ----
// checker on the top ports of the dac latch control block
`timescale 1ns/1ps
module dsl_top_props
    import dsl_pkg::*;
(
    // clock, reset and pins
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic                  reset_n,
    input wire logic                  power_down_input,
    input wire logic                  latch_load_n,
    input wire logic                  reset_value_select,
    input wire logic                  sclk,
    input wire logic                  cs_n,
    // device outputs
    input wire logic                  sdo,
    input wire logic                  sdo_oe,
    input wire logic [DSL_CODE_W-1:0] dac_code,
    input wire logic                  gain_two,
    input wire logic                  out_ground_10k,
    input wire logic                  word_ready
);
    // pin reset acts through a synchroniser, so both resets mute the checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst || !reset_n);

    oe_off_a: assert property (cs_n [*4] |-> !sdo_oe) else $error("sdo driven while deselected");
    oe_on_a: assert property ($fell(cs_n) ##1 !cs_n [*3] |-> sdo_oe) else $error("sdo not driven in frame");
    reset_code_a: assert property ($fell(rst) |->
        dac_code == (reset_value_select ? DSL_RESET_MID : DSL_RESET_ZERO)) else $error("bad reset code");
    gain_held_a: assert property ($stable(gain_two)) else $error("gain moved in operation");
    pd_ground_a: assert property ($stable(power_down_input) [*4] |->
        out_ground_10k == power_down_input) else $error("power-down not followed");
    latch_hold_a: assert property (latch_load_n [*4] |=> $stable(dac_code)) else $error("code moved, latch shut");
    buf_space_a: assert property (word_ready) else $error("buffer lost space");
    sdo_hold_a: assert property ($stable(sclk) [*6] ##0 sdo_oe && $past(sdo_oe, 2) |->
        $stable(sdo)) else $error("sdo moved without clock");
    // main scenarios reached
    cover property ($rose(sdo_oe));
    cover property ($rose(out_ground_10k));
    cover property (!latch_load_n ##1 $changed(dac_code));
endmodule
bind dsl_top dsl_top_props dsl_top_props_i (.ref_clk, .rst, .reset_n, .power_down_input, .latch_load_n,
    .reset_value_select, .sclk, .cs_n, .sdo, .sdo_oe, .dac_code, .gain_two, .out_ground_10k, .word_ready);

// ---- bench/dsl_host.sv ----
// host link controller model that frames words toward the device
`timescale 1ns/1ps
module dsl_host (
    // link lines
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo
);
    // one frame, msb first, n clocks; readback taken at each rising clock
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
        rd = 16'h0000;
        cs_n = 1'b0;
        #96;
        for (int b = 15; b > 15 - n; b--) begin
            sdi = w[b];
            #32 sclk = 1'b1;
            rd = {rd[14:0], sdo};
            #32 sclk = 1'b0;
        end
        #32 cs_n = 1'b1;
        sdi = ~sdi; // a released line must not keep its last bit
        #64;
    endtask
    // stray clocks with the device deselected
    task automatic stray(input int n);
        repeat (2 * n) #32 sclk = ~sclk;
    endtask
    // link clock starts low with the device deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
endmodule

// ---- bench/dsl_top_tb_top.sv ----
// self-checking bench for the dac latch control block
`timescale 1ns/1ps
module dsl_top_tb_top;
    import dsl_pkg::*;
    logic        ref_clk = 1'b0, rst = 1'b1, reset_n = 1'b1, pdi = 1'b0, ldn = 1'b0;
    logic [3:0]  cfg = 4'h0; // reset select, gain, format, readback select
    logic [15:0] w, x, v, rd;
    int          bad_count = 0, tests_run = 0;
    wire         sclk, cs_n, sdi, sdo, sdo_oe, sdo_line, gain_two, ogk, word_ready;
    wire  [15:0] dac_code;

    dsl_top dsl_top_i (.ref_clk, .rst, .reset_n, .power_down_input(pdi), .latch_load_n(ldn),
        .reset_value_select(cfg[0]), .gain_select(cfg[1]), .data_format_select(cfg[2]),
        .serial_out_select(cfg[3]), .sclk, .cs_n, .sdi, .sdo, .sdo_oe, .dac_code, .gain_two,
        .out_ground_10k(ogk), .word_ready);
    // a released line shows the inverse bit, so a late enable corrupts readback
    assign sdo_line = sdo_oe ? sdo : ~sdo;
    dsl_host dsl_host_i (.sclk, .cs_n, .sdi, .sdo(sdo_line));

    initial forever #4 ref_clk = ~ref_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // model of the code conversion: two's complement flips the msb
    function automatic logic [15:0] cv(input logic [15:0] c);
        return cfg[2] ? c : c ^ DSL_SIGN_FLIP;
    endfunction
    task automatic do_reset(input logic [3:0] c);
        rst = 1'b1;
        cfg = c;
        cyc(20);
        rst = 1'b0;
        cyc(1);
        chk(dac_code, c[0] ? DSL_RESET_MID : DSL_RESET_ZERO);
        chk({15'h0, gain_two}, {15'h0, c[1]});
    endtask

    // hang guard well beyond the full sequence
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
    // four strap settings, each strap at both levels: full word, short frame, stray clocks, held latch
    initial begin
        void'($urandom(86));
        cyc(1);
        for (int i = 0; i < 4; i++) begin
            do_reset({i[0], i[1], i[0] | i[1], i[1] ^ i[0]});
            w = 16'($urandom);
            x = 16'($urandom);
            v = 16'($urandom);
            chk({15'h0, word_ready}, 16'h0001);
            dsl_host_i.xfer(w, 16, rd);
            cyc(8);
            chk(dac_code, cv(w));
            dsl_host_i.xfer(x, 8, rd);
            dsl_host_i.stray(8);
            cyc(8);
            chk(dac_code, cv(w));
            ldn = 1'b1;
            dsl_host_i.xfer(v, 16, rd);
            chk(rd, cfg[3] ? cv(w) : {w[7:0], x[15:8]});
            chk({15'h0, sdo_oe}, 16'h0000);
            cyc(8);
            chk(dac_code, cv(w));
            ldn = 1'b0;
            cyc(6);
            chk(dac_code, cv(v));
            pdi = 1'b1;
            cfg[1] = ~cfg[1];
            cyc(6);
            chk({14'h0, ogk, gain_two}, {14'h0, 1'b1, ~cfg[1]});
            pdi = 1'b0;
            cfg[1] = ~cfg[1];
            reset_n = 1'b0;
            cyc(5);
            reset_n = 1'b1;
            cyc(4);
            chk(dac_code, cfg[0] ? DSL_RESET_MID : DSL_RESET_ZERO);
        end
        stop_test();
    end
endmodule
